// ### hw/epe_pkg.sv
/*
 * shared constants and types for the parallel port cycle engine:
 * register indices, field positions, reset values, watchdog timing.
 * assumes a 10 MHz system clock and 32-bit classic wishbone access.
 */
package epe_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    // longest time, so the cycle count rounds down
    localparam int unsigned WD_TIME_NS = 10_000;
    localparam int unsigned WD_CYCLES = WD_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned WD_W = 8;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_SPP_DATA = 4'h0;
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_CONTROL = 4'h2;
    localparam logic [3:0] IDX_EPP_ADDR = 4'h3;
    localparam logic [3:0] IDX_EPP_DATA0 = 4'h4;
    localparam logic [3:0] IDX_EPP_DATA3 = 4'h7;
    localparam logic [3:0] IDX_CONFIG = 4'h8;

    // control fields
    localparam int unsigned CTL_STROBE = 0;
    localparam int unsigned CTL_AUTOFD = 1;
    localparam int unsigned CTL_INIT = 2;
    localparam int unsigned CTL_SELIN = 3;
    localparam int unsigned CTL_IRQE = 4;
    localparam int unsigned CTL_PCD = 5;
    // status fields
    localparam int unsigned ST_TIMEOUT = 0;
    localparam int unsigned ST_WAIT = 1;
    localparam int unsigned ST_PERIPHERAL_INTERRUPT = 2;
    localparam int unsigned ST_BUSY = 3;
    // config fields
    localparam int unsigned CFG_PRST = 0;

    localparam logic [5:0] CTL_RST = 6'h00;
    localparam logic [7:0] PDO_RST = 8'h00;

    typedef enum logic [1:0] {
        EPE_IDLE = 2'h0,
        EPE_ARM = 2'h1,
        EPE_STRB = 2'h3,
        EPE_DONE = 2'h2
    } epe_state_t;

    typedef struct packed {
        epe_state_t state;
        logic mode19;
        logic wr;
        logic addr_cyc;
        logic abort;
        logic ack;
        logic timeout;
        logic prst;
        logic irq;
        logic [5:0] ctrl;
        logic [7:0] pdo;
        logic [7:0] rdat;
    } epe_regs_t;

    localparam epe_regs_t REGS_RST = '{
        state: EPE_IDLE, mode19: 1'b0, wr: 1'b0, addr_cyc: 1'b0,
        abort: 1'b0, ack: 1'b0, timeout: 1'b0, prst: 1'b0, irq: 1'b0,
        ctrl: CTL_RST, pdo: PDO_RST, rdat: 8'h00};

endpackage : epe_pkg

// ### hw/epe_watchdog.sv
/*
 * cycle watchdog: counts clocks while a port cycle runs and pulses
 * expired_o on the last allowed cycle.
 * assumes run_i drops as soon as the owner reacts to the pulse.
 */
`timescale 1ns/1ps
module epe_watchdog
    import epe_pkg::*;
#(
    parameter int unsigned CYCLES = WD_CYCLES,
    parameter int unsigned W = WD_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic expired_o
);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (rst_i || !run_i) begin
            nxt_cnt = '0;
        end else if (cnt_ff != W'(CYCLES - 1)) begin
            nxt_cnt = cnt_ff + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        cnt_ff <= nxt_cnt;
    end

    assign expired_o = run_i && (cnt_ff == W'(CYCLES - 1));

endmodule : epe_watchdog

// ### hw/epe_cycle_engine.sv
/*
 * enhanced parallel port cycle engine: wishbone register slave, legacy
 * port control pins and the handshake for both enhanced port variants.
 * assumes peripheral pins synchronous to clk_i and a static mode input.
 */
// Operation
// - newer variant: hold bus answer back from each read start until done
// - newer variant: wait already low at strobe, finish once wait rises
// - newer variant: wait high at start, hold strobes and write line
// - newer read: float data bus, release write line, direction high
// - newer read end: capture byte, drop strobe, return byte, answer host
// - no cycle running: legacy pins follow control register
// - watchdog aborts cycle after ten microseconds, sets status bit zero
// - older variant: hold answer while wait low, release on high or timeout
// - older write: drive byte and assert address or data strobe on the same edge
// - older write: strobe ends when host ends its write
// - older read: write line released, bus floated, strobe asserted
// - older read: strobe ends when host read ends
// - write, data strobe and address strobe outputs are active low
// - peripheral interrupt passes through uninverted, active high
// - active low reset output returns peripheral to initial mode
// - direction low for write, high for control bit or enhanced read
// - during a cycle control port overrides only the write line
// - offset three runs address cycles, four to seven data cycles
`timescale 1ns/1ps
module epe_cycle_engine
    import epe_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic epp19_mode_i,
    input wire logic peripheral_wait_n_i,
    input wire logic peripheral_interrupt_i,
    input wire logic [7:0] port_data_bus_i,
    output logic [7:0] port_data_bus_o,
    output logic port_data_bus_oe_n_o,
    output logic port_direction_o,
    output logic peripheral_write_n_o,
    output logic data_strobe_n_o,
    output logic address_strobe_n_o,
    output logic strobe_n_o,
    output logic autofeed_n_o,
    output logic init_n_o,
    output logic select_in_n_o,
    output logic peripheral_reset_n_o,
    output logic peripheral_interrupt_o
);

    ////////////////////////////////////////////////////////////////////
    // state and decode

    epe_regs_t regs_ff;
    epe_regs_t nxt_regs;
    logic req;
    logic [3:0] idx;
    logic epp_hit;
    logic wr_now;
    logic wd_run;
    logic wd_expired;
    logic in_cycle;
    logic stb_on;
    logic [7:0] status;

    assign req = wb_cyc_i && wb_stb_i;
    assign idx = wb_adr_i[5:2];
    assign epp_hit = (idx >= IDX_EPP_ADDR) && (idx <= IDX_EPP_DATA3);
    // pcd set turns a newer-variant write into a read, with no error
    assign wr_now = epp19_mode_i ? (wb_we_i && !regs_ff.ctrl[CTL_PCD])
                                 : !regs_ff.ctrl[CTL_PCD];
    assign wd_run = (regs_ff.state == EPE_ARM)
                 || (regs_ff.state == EPE_STRB);
    assign in_cycle = (regs_ff.state == EPE_STRB)
                   || (regs_ff.state == EPE_DONE);

    assign status = {4'h0, (regs_ff.state != EPE_IDLE), regs_ff.irq,
                     peripheral_wait_n_i, regs_ff.timeout};

    ////////////////////////////////////////////////////////////////////
    // watchdog

    epe_watchdog #(
        .CYCLES(WD_CYCLES),
        .W(WD_W)
    ) u_watchdog (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(wd_run),
        .expired_o(wd_expired)
    );

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_regs = regs_ff;
        nxt_regs.ack = 1'b0;
        nxt_regs.irq = peripheral_interrupt_i;
        case (regs_ff.state)
            EPE_IDLE: begin
                if (req && !regs_ff.ack && epp_hit) begin
                    nxt_regs.mode19 = epp19_mode_i;
                    nxt_regs.addr_cyc = (idx == IDX_EPP_ADDR);
                    nxt_regs.wr = wr_now;
                    nxt_regs.abort = 1'b0;
                    if (wr_now) begin
                        nxt_regs.pdo = wb_dat_i[7:0];
                    end
                    // newer variant waits for wait low first
                    if (epp19_mode_i && peripheral_wait_n_i) begin
                        nxt_regs.state = EPE_ARM;
                    end else begin
                        nxt_regs.state = EPE_STRB;
                    end
                end else if (req && !regs_ff.ack) begin
                    nxt_regs.ack = 1'b1;
                    case (idx)
                        IDX_SPP_DATA: nxt_regs.rdat = regs_ff.pdo;
                        IDX_STATUS: nxt_regs.rdat = status;
                        IDX_CONTROL: nxt_regs.rdat = {2'b00, regs_ff.ctrl};
                        IDX_CONFIG: nxt_regs.rdat = {7'h00, regs_ff.prst};
                        default: nxt_regs.rdat = 8'h00;
                    endcase
                    if (wb_we_i && wb_sel_i[0]) begin
                        case (idx)
                            IDX_SPP_DATA: nxt_regs.pdo = wb_dat_i[7:0];
                            IDX_STATUS: begin
                                if (wb_dat_i[ST_TIMEOUT]) begin
                                    nxt_regs.timeout = 1'b0;
                                end
                            end
                            IDX_CONTROL: nxt_regs.ctrl = wb_dat_i[5:0];
                            IDX_CONFIG: nxt_regs.prst = wb_dat_i[CFG_PRST];
                            default: nxt_regs.rdat = nxt_regs.rdat;
                        endcase
                    end
                end
            end
            EPE_ARM: begin
                if (wd_expired) begin
                    nxt_regs.timeout = 1'b1;
                    nxt_regs.abort = 1'b1;
                    nxt_regs.ack = 1'b1;
                    nxt_regs.rdat = 8'h00;
                    nxt_regs.state = EPE_DONE;
                end else if (!peripheral_wait_n_i) begin
                    nxt_regs.state = EPE_STRB;
                end
            end
            EPE_STRB: begin
                if (wd_expired) begin
                    nxt_regs.timeout = 1'b1;
                    nxt_regs.abort = 1'b1;
                    nxt_regs.ack = 1'b1;
                    nxt_regs.rdat = 8'h00;
                    nxt_regs.state = EPE_DONE;
                end else if (peripheral_wait_n_i) begin
                    // answer only once wait is high
                    nxt_regs.ack = 1'b1;
                    if (!regs_ff.wr) begin
                        nxt_regs.rdat = port_data_bus_i;
                    end
                    nxt_regs.state = EPE_DONE;
                end
            end
            EPE_DONE: begin
                // older variant keeps its strobe until the host lets go
                if (!req) begin
                    nxt_regs.state = EPE_IDLE;
                end
            end
            default: nxt_regs.state = EPE_IDLE;
        endcase
        if (rst_i) begin
            nxt_regs = REGS_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        regs_ff <= nxt_regs;
    end

    ////////////////////////////////////////////////////////////////////
    // pins

    // newer variant drops its strobe at termination, older holds it
    assign stb_on = (regs_ff.state == EPE_STRB)
                 || ((regs_ff.state == EPE_DONE) && !regs_ff.mode19
                     && !regs_ff.abort);
    assign data_strobe_n_o = !(stb_on && !regs_ff.addr_cyc);
    assign address_strobe_n_o = !(stb_on && regs_ff.addr_cyc);

    always_comb begin
        if (in_cycle) begin
            // control strobe bit may still force a write during a cycle
            peripheral_write_n_o = !(regs_ff.wr
                                     || regs_ff.ctrl[CTL_STROBE]);
        end else if (epp19_mode_i) begin
            peripheral_write_n_o = 1'b1;
        end else begin
            peripheral_write_n_o = regs_ff.ctrl[CTL_PCD];
        end
    end

    assign port_direction_o = regs_ff.ctrl[CTL_PCD]
                           || (in_cycle && !regs_ff.wr);
    assign port_data_bus_oe_n_o = port_direction_o;
    assign port_data_bus_o = regs_ff.pdo;

    assign strobe_n_o = !regs_ff.ctrl[CTL_STROBE];
    assign autofeed_n_o = !regs_ff.ctrl[CTL_AUTOFD];
    assign init_n_o = regs_ff.ctrl[CTL_INIT];
    assign select_in_n_o = !regs_ff.ctrl[CTL_SELIN];
    assign peripheral_reset_n_o = !regs_ff.prst;
    assign peripheral_interrupt_o = regs_ff.irq;

    assign wb_ack_o = regs_ff.ack;
    assign wb_dat_o = {24'h000000, regs_ff.rdat};

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // helper: cycles spent in a running port cycle
    logic [WD_W-1:0] run_len_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i || !wd_run) begin
            run_len_ff <= '0;
        end else begin
            run_len_ff <= run_len_ff + WD_W'(1);
        end
    end

    sequence s_strobe_wait_high;
        (regs_ff.state == EPE_STRB) && peripheral_wait_n_i && !wd_expired;
    endsequence

    sequence s_answer_read;
        wb_ack_o && (regs_ff.state == EPE_DONE);
    endsequence

    sequence s_held_older;
        (regs_ff.state == EPE_DONE) && !regs_ff.mode19 && !regs_ff.abort;
    endsequence

    arm_no_answer_a: assert property (
        (regs_ff.state == EPE_ARM) |-> !wb_ack_o)
        else $error("answer given before strobe phase");

    arm_hold_pins_a: assert property (
        (regs_ff.state == EPE_ARM) ##1 (regs_ff.state == EPE_ARM)
        |-> data_strobe_n_o && address_strobe_n_o
            && $stable(peripheral_write_n_o))
        else $error("pins moved while waiting for wait low");

    read_float_a: assert property (
        (regs_ff.state == EPE_STRB) && !regs_ff.wr
        |-> port_direction_o && port_data_bus_oe_n_o)
        else $error("bus driven during read strobe");

    term_capture_a: assert property (
        s_strobe_wait_high ##0 !regs_ff.wr
        |=> s_answer_read ##0
            (wb_dat_o[7:0] == $past(port_data_bus_i)))
        else $error("read byte not captured at termination");

    newer_drop_a: assert property (
        s_strobe_wait_high ##0 regs_ff.mode19
        |=> data_strobe_n_o && address_strobe_n_o)
        else $error("strobe still active after termination");

    wait_low_hold_a: assert property (
        (regs_ff.state == EPE_STRB) && !peripheral_wait_n_i && !wd_expired
        |=> !wb_ack_o)
        else $error("answer given while wait is low");

    watchdog_limit_a: assert property (
        wd_run |-> (run_len_ff < WD_W'(WD_CYCLES)))
        else $error("cycle outlived the watchdog");

    watchdog_abort_a: assert property (
        wd_expired |=> wb_ack_o && regs_ff.timeout
                      && data_strobe_n_o && address_strobe_n_o)
        else $error("watchdog expiry did not abort");

    older_hold_a: assert property (
        s_held_older ##0 req |-> !(data_strobe_n_o && address_strobe_n_o))
        else $error("older strobe dropped before host release");

    strobe_select_a: assert property (
        !address_strobe_n_o |-> regs_ff.addr_cyc && data_strobe_n_o)
        else $error("wrong strobe for the cycle kind");

    direction_low_a: assert property (
        !regs_ff.ctrl[CTL_PCD] && (!in_cycle || regs_ff.wr)
        |-> !port_direction_o)
        else $error("direction high without cause");

    irq_pass_a: assert property (
        ##1 (peripheral_interrupt_o == $past(peripheral_interrupt_i)))
        else $error("interrupt not passed through");

    sequence s_take_wait_high;
        (regs_ff.state == EPE_IDLE) && req && !wb_ack_o && epp_hit
            && epp19_mode_i && peripheral_wait_n_i;
    endsequence

    arm_entry_a: assert property (
        s_take_wait_high |=> (regs_ff.state == EPE_ARM)
            && data_strobe_n_o && address_strobe_n_o)
        else $error("strobe raised while wait was high");

    write_drive_a: assert property (
        (regs_ff.state == EPE_STRB) && regs_ff.wr
        |-> !port_data_bus_oe_n_o && !peripheral_write_n_o)
        else $error("write byte not driven on the port bus");

    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("answer held longer than one cycle");

    timeout_sticky_a: assert property (
        regs_ff.timeout && (regs_ff.state != EPE_IDLE) |=> regs_ff.timeout)
        else $error("timeout flag lost during a cycle");

    read_dir_a: assert property (
        in_cycle && !regs_ff.wr |-> port_direction_o)
        else $error("direction low during a read cycle");

endmodule : epe_cycle_engine

// ### verification/epe_peripheral.sv
/*
 * behavioural peripheral on the enhanced port cable: answers strobes
 * with the wait line, drives a byte on reads, floats afterwards.
 * assumes pins synchronous to clk_i; the bench sets delay and silence.
 */
`timescale 1ns/1ps
module epe_peripheral (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic data_strobe_n_i,
    input wire logic address_strobe_n_i,
    input wire logic peripheral_write_n_i,
    input wire logic bus_oe_n_i,
    input wire logic [7:0] bus_dev_i,
    input wire logic [7:0] byte_i,
    input wire logic [3:0] delay_i,
    input wire logic mute_i,
    input wire logic busy_idle_i,
    output logic peripheral_wait_n_o,
    output logic [7:0] port_data_bus_o
);
    logic drv_ff;
    logic [3:0] cnt_ff;
    logic [7:0] last_ff;
    logic strb;

    assign strb = !data_strobe_n_i || !address_strobe_n_i;
    // released bus shows the inverse, never a stale copy
    assign port_data_bus_o = !bus_oe_n_i ? bus_dev_i :
        drv_ff ? byte_i : ~last_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_ff <= 1'b0;
            cnt_ff <= 4'h0;
            last_ff <= 8'h00;
            peripheral_wait_n_o <= 1'b0;
        end else if (strb) begin
            drv_ff <= peripheral_write_n_i;
            if (cnt_ff != 4'hF) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
            // byte is out at least one cycle before wait rises
            if (cnt_ff > delay_i && !mute_i) begin
                peripheral_wait_n_o <= 1'b1;
            end
        end else begin
            cnt_ff <= 4'h0;
            drv_ff <= 1'b0;
            if (drv_ff) begin
                last_ff <= byte_i;
            end
            peripheral_wait_n_o <= drv_ff ? 1'b1 : busy_idle_i;
        end
    end
endmodule : epe_peripheral

// ### verification/epe_cycle_engine_tb.sv
/*
 * bench for the cycle engine: legacy pins, both handshakes, watchdog.
 * assumes the peripheral model in epe_peripheral.sv.
 */
`timescale 1ns/1ps
module epe_cycle_engine_tb;
    import epe_pkg::*;
    logic clk_i, rst_i, cyc, we, mode, peripheral_interrupt, mute, busy, ack, waitn;
    logic [5:0] adr;
    logic [31:0] wdat, dat_o, rd;
    logic [3:0] dly;
    logic [7:0] pbyte, pdb, pdo;
    logic oen, dir, wrn, dsn, asn, stbn, afn, initn, selinn, prstn, intro;
    logic seen_ds, seen_as, s_dir, s_wrn, s_oen;
    logic [7:0] s_pdo;
    int n_errors = 0;
    int n_compared = 0;

    epe_cycle_engine i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .epp19_mode_i(mode), .peripheral_wait_n_i(waitn),
        .peripheral_interrupt_i(peripheral_interrupt), .port_data_bus_i(pdb),
        .port_data_bus_o(pdo), .port_data_bus_oe_n_o(oen),
        .port_direction_o(dir), .peripheral_write_n_o(wrn),
        .data_strobe_n_o(dsn), .address_strobe_n_o(asn),
        .strobe_n_o(stbn), .autofeed_n_o(afn), .init_n_o(initn),
        .select_in_n_o(selinn), .peripheral_reset_n_o(prstn),
        .peripheral_interrupt_o(intro));
    epe_peripheral i_per (.clk_i(clk_i), .rst_i(rst_i),
        .data_strobe_n_i(dsn), .address_strobe_n_i(asn),
        .peripheral_write_n_i(wrn), .bus_oe_n_i(oen), .bus_dev_i(pdo),
        .byte_i(pbyte), .delay_i(dly), .mute_i(mute), .busy_idle_i(busy),
        .peripheral_wait_n_o(waitn), .port_data_bus_o(pdb));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (!dsn) seen_ds <= 1'b1;
        if (!asn) seen_as <= 1'b1;
        if (!dsn || !asn) begin
            s_dir <= dir;
            s_wrn <= wrn;
            s_oen <= oen;
            s_pdo <= pdo;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // entered just after a rising edge; waits for ack, bounded
    task automatic bus(input logic w, input logic [3:0] idx,
        input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 400);
        rd = dat_o;
        chk({31'h0, ack}, 32'h1);
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    ////////////////////////////////////////////////////////////////////////
    task automatic t_legacy;
        chk({dsn, asn, initn, prstn, dir, ack}, 32'h34);
        bus(1'b1, 4'h2, 8'h0F);
        chk({stbn, afn, initn, selinn}, 32'h2);
        bus(1'b1, 4'h2, 8'h20);
        chk({31'h0, dir}, 32'h1);
        bus(1'b1, 4'h2, 8'h00);
        chk({31'h0, dir}, 32'h0);
    endtask : t_legacy
    task automatic t_new_read;
        for (int i = 3; i < 8; i++) begin
            pbyte <= 8'hA0 + i[7:0];
            dly <= i[3:0] - 4'h3;
            seen_ds = 1'b0;
            seen_as = 1'b0;
            bus(1'b0, i[3:0], 8'h00);
            chk(rd, 32'hA0 + i);
            chk({seen_as, seen_ds}, (i == 3) ? 32'h2 : 32'h1);
            chk({s_dir, s_oen, s_wrn}, 32'h7);
        end
    endtask : t_new_read
    task automatic t_new_busy;
        busy <= 1'b1;
        pbyte <= 8'h69;
        // let the wait line settle high before the host starts
        repeat (2) @(posedge clk_i);
        seen_ds = 1'b0;
        fork
            bus(1'b0, 4'h4, 8'h00);
            begin
                repeat (6) @(posedge clk_i);
                chk({31'h0, seen_ds}, 32'h0);
                busy <= 1'b0;
            end
        join
        chk(rd, 32'h69);
    endtask : t_new_busy
    task automatic t_old;
        mode <= 1'b0;
        dly <= 4'h2;
        seen_as = 1'b0;
        bus(1'b1, 4'h3, 8'h3C);
        chk({seen_as, s_pdo, s_wrn, s_dir}, 32'h4F0);
        @(posedge clk_i);
        chk({31'h0, asn}, 32'h1);
        bus(1'b1, 4'h2, 8'h20);
        pbyte <= 8'h5A;
        seen_ds = 1'b0;
        bus(1'b0, 4'h6, 8'h00);
        chk(rd, 32'h5A);
        chk({seen_ds, s_wrn, s_oen, s_dir}, 32'hF);
        @(posedge clk_i);
        chk({31'h0, dsn}, 32'h1);
        bus(1'b1, 4'h2, 8'h00);
    endtask : t_old
    task automatic t_timeout;
        mute <= 1'b1;
        bus(1'b1, 4'h4, 8'h77);
        mute <= 1'b0;
        bus(1'b0, 4'h1, 8'h00);
        chk({31'h0, rd[0]}, 32'h1);
        bus(1'b1, 4'h1, 8'h01);
        bus(1'b0, 4'h1, 8'h00);
        chk({31'h0, rd[0]}, 32'h0);
    endtask : t_timeout
    task automatic t_misc;
        peripheral_interrupt <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({31'h0, intro}, 32'h1);
        peripheral_interrupt <= 1'b0;
        bus(1'b1, 4'h8, 8'h01);
        chk({31'h0, prstn}, 32'h0);
        bus(1'b1, 4'h8, 8'h00);
        chk({31'h0, prstn}, 32'h1);
        bus(1'b0, 4'h9, 8'h00);
        chk(rd, 32'h0);
    endtask : t_misc
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {cyc, we, peripheral_interrupt, mute, busy} = 5'h00;
        mode = 1'b1;
        adr = 6'h00;
        wdat = 32'h00000000;
        dly = 4'h0;
        pbyte = 8'h00;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_legacy();
        t_new_read();
        t_new_busy();
        t_old();
        t_timeout();
        t_misc();
        stop_test();
    end
    // tests need under three hundred cycles; the limit allows twenty thousand
    initial begin
        #2_000_000;
        n_errors++;
        stop_test();
    end
endmodule : epe_cycle_engine_tb
